//--- logic/tos_regs.svh
`ifndef TOS_REGS_SVH
`define TOS_REGS_SVH

// ****************************************************************
// register map
// ****************************************************************
`define TOS_A_CTRL     8'h00
`define TOS_A_ARM      8'h04
`define TOS_A_TGT      8'h08
`define TOS_A_START_LO 8'h0C
`define TOS_A_START_HI 8'h10
`define TOS_A_CYCLE    8'h14
`define TOS_A_STATUS   8'h18
`define TOS_A_CH_CTRL  6'h00
`define TOS_A_CH_EV0   6'h04
`define TOS_A_CH_EVN   6'h28
`define TOS_A_CH_STAT  6'h30

// ****************************************************************
// fields and values
// ****************************************************************
`define TOS_ARM_IDLE   8'h00
`define TOS_ARM_GO     8'h03
`define TOS_F_FLUSH    0
`define TOS_F_MLVL     1
`define TOS_F_FORCE    2
`define TOS_F_MEN      3
`define TOS_F_ORD      8
`define TOS_F_NEV      16
`define TOS_F_EVLVL    20
`define TOS_MAX_EV     10

// ****************************************************************
// timing
// ****************************************************************
`define TOS_CLK_MHZ    100
`define TOS_TICK_US    25
`define TOS_TICK_CYC   (`TOS_TICK_US * `TOS_CLK_MHZ)
`define TOS_TICK_NS    (`TOS_TICK_US * 1000)
`define TOS_LATE_US    100
`define TOS_LATE_NS    (`TOS_LATE_US * 1000)

`endif

//--- logic/tos_pkg.sv
`default_nettype none
package tos_pkg;
  typedef enum logic {ORD_IDLE = 1'b0, ORD_PEND = 1'b1} ord_t;
  typedef enum logic {LD_IDLE = 1'b0, LD_LOAD = 1'b1} ld_t;

  typedef struct packed {
    ld_t              ld;
    logic [3:0]       idx;
    logic [3:0]       left;
    logic             ovf;
    logic             lvl;
    logic             scan;
    logic             man_lvl;
    logic             force_old;
    logic             man_en;
    logic [7:0]       ord_ctr;
    logic [7:0]       ord_seen;
    logic [3:0]       n_ev;
    logic [9:0]       ev_lvl;
    logic [9:0][31:0] ev_time;
  } chan_t;

  typedef struct packed {
    chan_t [1:0] ch;
    ord_t        ord;
    logic        multi;
    logic        tcheck;
    logic [3:0]  osf;
    logic [7:0]  arm;
    logic [7:0]  arm_prev;
    logic [3:0]  tgt;
    logic [3:0]  ord_tgt;
    logic [3:0]  fb;
    logic [63:0] start;
    logic [63:0] ord_time;
    logic [7:0]  in_ctr;
    logic [31:0] rdata;
    logic [1:0]  out;
    logic [1:0]  hiz;
  } core_t;
endpackage : tos_pkg
`default_nettype wire

//--- logic/tos_tick.sv
`timescale 1ns/1ns
`default_nettype none
`include "tos_regs.svh"
module tos_tick #(
  parameter int CYC = `TOS_TICK_CYC
) (
  input  wire logic clk,
  input  wire logic rst,
  output logic      tick
);
  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } tick_t;
  tick_t st;
  tick_t next;

  always_comb begin
    next = st;
    next.tick = 1'b0;
    if (st.cnt == 16'(CYC - 1)) begin
      next.cnt  = 16'h0000;
      next.tick = 1'b1;
    end else begin
      next.cnt = st.cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) st <= '0;
    else     st <= next;
  end

  assign tick = st.tick;
endmodule : tos_tick
`default_nettype wire

//--- logic/tos_evt_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module tos_evt_fifo #(
  parameter int DEPTH = 16,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        flush,
  input  wire logic        push,
  input  wire logic [31:0] push_time,
  input  wire logic        push_lvl,
  input  wire logic        pop,
  output logic      [31:0] head_time,
  output logic             head_lvl,
  output logic             empty,
  output logic      [AW:0] count
);
  typedef struct packed {
    logic [DEPTH-1:0][32:0] mem;
    logic [AW-1:0]          wp;
    logic [AW-1:0]          rp;
    logic [AW:0]            cnt;
  } fifo_t;
  fifo_t st;
  fifo_t next;
  logic  do_push;
  logic  do_pop;

  always_comb begin
    next    = st;
    do_push = push && (st.cnt != (AW + 1)'(DEPTH));
    do_pop  = pop && (st.cnt != '0);
    if (do_push) begin
      next.mem[st.wp] = {push_lvl, push_time};
      next.wp         = st.wp + 1'b1;
    end
    if (do_pop) next.rp = st.rp + 1'b1;
    next.cnt = st.cnt + (AW + 1)'(do_push) - (AW + 1)'(do_pop);
    if (flush) begin
      next.wp  = '0;
      next.rp  = '0;
      next.cnt = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) st <= '0;
    else     st <= next;
  end

  assign head_time = st.mem[st.rp][31:0];
  assign head_lvl  = st.mem[st.rp][32];
  assign empty     = (st.cnt == '0);
  assign count     = st.cnt;
endmodule : tos_evt_fifo
`default_nettype wire

//--- logic/tos_core.sv
// Chosen here: strobed register access and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "tos_regs.svh"
module tos_core
  import tos_pkg::*;
#(
  parameter int DEPTH = 16,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic        CLK,
  input  wire logic        SYS_RST,
  input  wire logic [7:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [31:0] RDATA,
  input  wire logic [63:0] SYS_TIME,
  output logic      [1:0]  CH_OUT,
  output logic      [1:0]  CH_HIZ
);
  // ****************************************************************
  // decode helpers
  // ****************************************************************
  function automatic logic chan_hit(input logic [7:0] a, input int c);
    return a[7:6] == 2'(c + 1);
  endfunction : chan_hit

  function automatic logic is_ev(input logic [5:0] a);
    return (a >= `TOS_A_CH_EV0) && (a <= `TOS_A_CH_EVN) && (a[1:0] == 2'b00);
  endfunction : is_ev

  function automatic logic [3:0] ev_idx(input logic [5:0] a);
    logic [5:0] d;
    d = a - `TOS_A_CH_EV0;
    return d[5:2];
  endfunction : ev_idx

  function automatic logic [3:0] osf_max(input logic [1:0] code);
    logic [3:0] r;
    unique case (code)
      2'h0: r = 4'h1;
      2'h1: r = 4'h2;
      2'h2: r = 4'h5;
      2'h3: r = 4'hA;
    endcase
    return r;
  endfunction : osf_max

  // ****************************************************************
  // state and submodules
  // ****************************************************************
  core_t                  st;
  core_t                  next;
  logic                   tick;
  logic                   commit;
  logic                   accept;
  logic                   due_single;
  logic [1:0]             f_push;
  logic [1:0]             f_pop;
  logic [1:0]             f_flush;
  logic [1:0]             f_empty;
  logic [1:0]             f_lvl;
  logic [1:0]             push_lvl;
  logic [1:0][31:0]       push_time;
  logic [1:0][31:0]       f_time;
  logic [1:0][AW:0]       f_cnt;
  logic [31:0]            diff;
  logic [31:0]            rd_val;
  logic [3:0]             want;
  logic [7:0]             free;

  tos_tick u_tick (
    .clk  (CLK),
    .rst  (SYS_RST),
    .tick (tick)
  );

  for (genvar g = 0; g < 2; g++) begin : g_fifo
    tos_evt_fifo #(.DEPTH(DEPTH)) u_fifo (
      .clk       (CLK),
      .rst       (SYS_RST),
      .flush     (f_flush[g]),
      .push      (f_push[g]),
      .push_time (push_time[g]),
      .push_lvl  (push_lvl[g]),
      .pop       (f_pop[g]),
      .head_time (f_time[g]),
      .head_lvl  (f_lvl[g]),
      .empty     (f_empty[g]),
      .count     (f_cnt[g])
    );
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    next       = st;
    f_push     = '0;
    f_pop      = '0;
    f_flush    = '0;
    push_lvl   = '0;
    push_time  = '0;
    diff       = 32'h0000_0000;
    rd_val     = 32'h0000_0000;
    want       = 4'h0;
    free       = 8'h00;
    commit     = WR && (ADDR == `TOS_A_CYCLE);
    accept     = commit && (st.arm_prev == `TOS_ARM_IDLE) && (st.arm == `TOS_ARM_GO);
    // full 64-bit compare against system time, 1 ns per bit
    due_single = (st.ord == ORD_PEND) && tick && (SYS_TIME >= st.ord_time);

    if (WR) begin
      case (ADDR)
        `TOS_A_CTRL: begin
          next.multi  = WDATA[0];
          next.tcheck = WDATA[1];
          next.osf    = WDATA[5:2];
        end
        `TOS_A_ARM:      next.arm         = WDATA[7:0];
        `TOS_A_TGT:      next.tgt         = WDATA[3:0];
        `TOS_A_START_LO: next.start[31:0] = WDATA;
        `TOS_A_START_HI: next.start[63:32] = WDATA;
        default: ;
      endcase
    end

    // one bus cycle ends on each commit; the arm byte is sampled here
    if (commit) begin
      next.arm_prev = st.arm;
      next.in_ctr   = st.in_ctr + 8'h01;
    end

    if (accept) begin
      next.ord      = ORD_PEND;
      next.ord_time = st.start;
      next.ord_tgt  = st.tgt;
    end else if (due_single) begin
      next.fb  = st.ord_tgt;
      next.ord = ORD_IDLE;
    end

    for (int c = 0; c < 2; c++) begin
      // loader moves one staged entry per clock into the buffer
      if (st.ch[c].ld == LD_LOAD) begin
        f_push[c]       = 1'b1;
        push_time[c]    = st.ch[c].ev_time[st.ch[c].idx];
        push_lvl[c]     = st.ch[c].ev_lvl[st.ch[c].idx];
        next.ch[c].idx  = st.ch[c].idx + 4'h1;
        next.ch[c].left = st.ch[c].left - 4'h1;
        if (st.ch[c].left == 4'h1) next.ch[c].ld = LD_IDLE;
      end

      if (commit && st.multi && (st.ch[c].ld == LD_IDLE)
          && (st.ch[c].ord_ctr != st.ch[c].ord_seen)) begin
        next.ch[c].ord_seen = st.ch[c].ord_ctr;
        want = (st.ch[c].n_ev < osf_max(st.osf[2*c +: 2]))
             ? st.ch[c].n_ev : osf_max(st.osf[2*c +: 2]);
        free = 8'(DEPTH) - 8'(f_cnt[c]);
        if (8'(want) > free) begin
          next.ch[c].ovf = 1'b1;
          want = 4'(free);
        end
        next.ch[c].idx  = 4'h0;
        next.ch[c].left = want;
        if (want != 4'h0) next.ch[c].ld = LD_LOAD;
      end

      // scan the head of the buffer once per tick until nothing is due
      if (st.ch[c].scan) begin
        if (f_empty[c]) begin
          next.ch[c].scan = 1'b0;
        end else begin
          diff = SYS_TIME[31:0] - f_time[c];
          if (st.tcheck) begin
            // signed difference gives the window of 2^31 ns each side
            if ($signed(diff) < 0) begin
              next.ch[c].scan = 1'b0;
            end else begin
              f_pop[c] = 1'b1;
              if ((diff < 32'(`TOS_TICK_NS)) || st.ch[c].force_old) begin
                next.ch[c].lvl = f_lvl[c];
              end
            end
          end else if (diff <= 32'(`TOS_LATE_NS)) begin
            f_pop[c]       = 1'b1;
            next.ch[c].lvl = f_lvl[c];
          end else begin
            next.ch[c].scan = 1'b0;
          end
        end
      end
      if (tick && st.multi) next.ch[c].scan = 1'b1;

      if (WR && chan_hit(ADDR, c)) begin
        if (ADDR[5:0] == `TOS_A_CH_CTRL) begin
          next.ch[c].man_lvl   = WDATA[`TOS_F_MLVL];
          next.ch[c].force_old = WDATA[`TOS_F_FORCE];
          next.ch[c].man_en    = WDATA[`TOS_F_MEN];
          next.ch[c].ord_ctr   = WDATA[`TOS_F_ORD +: 8];
          next.ch[c].n_ev      = WDATA[`TOS_F_NEV +: 4];
          next.ch[c].ev_lvl    = WDATA[`TOS_F_EVLVL +: `TOS_MAX_EV];
          if (WDATA[`TOS_F_FLUSH]) begin
            f_flush[c]      = 1'b1;
            next.ch[c].ovf  = 1'b0;
            next.ch[c].ld   = LD_IDLE;
            next.ch[c].left = 4'h0;
          end
        end else if (is_ev(ADDR[5:0])) begin
          next.ch[c].ev_time[ev_idx(ADDR[5:0])] = WDATA;
        end
      end
    end

    // outputs: without multi the scheduled order drives both channels, else event levels or the manual level where man_en is set
    if (st.multi) begin
      for (int c = 0; c < 2; c++) begin
        next.out[c] = st.ch[c].man_en ? st.ch[c].man_lvl : st.ch[c].lvl;
        next.hiz[c] = 1'b0;
      end
    end else begin
      next.hiz = {st.fb[3], st.fb[1]};
      next.out = {st.fb[2] & ~st.fb[3], st.fb[0] & ~st.fb[1]};
    end

    if (RD) begin
      case (ADDR)
        `TOS_A_CTRL:     rd_val = {26'h0, st.osf, st.tcheck, st.multi};
        `TOS_A_ARM:      rd_val = {24'h0, st.arm};
        `TOS_A_TGT:      rd_val = {28'h0, st.tgt};
        `TOS_A_START_LO: rd_val = st.start[31:0];
        `TOS_A_START_HI: rd_val = st.start[63:32];
        `TOS_A_STATUS:   rd_val = {16'h0, st.in_ctr, 3'h0, st.ord == ORD_PEND, st.fb};
        default: begin
          for (int c = 0; c < 2; c++) begin
            if (chan_hit(ADDR, c)) begin
              if (ADDR[5:0] == `TOS_A_CH_CTRL) begin
                rd_val = {2'h0, st.ch[c].ev_lvl, st.ch[c].n_ev, st.ch[c].ord_ctr,
                          4'h0, st.ch[c].man_en, st.ch[c].force_old,
                          st.ch[c].man_lvl, 1'b0};
              end else if (ADDR[5:0] == `TOS_A_CH_STAT) begin
                rd_val = {st.in_ctr, st.ch[c].ord_seen, 6'h0, st.out[c],
                          st.ch[c].ovf, 8'(f_cnt[c])};
              end else if (is_ev(ADDR[5:0])) begin
                rd_val = st.ch[c].ev_time[ev_idx(ADDR[5:0])];
              end
            end
          end
        end
      endcase
    end
    next.rdata = rd_val;
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) st <= '0;
    else         st <= next;
  end

  assign RDATA  = st.rdata;
  assign CH_OUT = st.out;
  assign CH_HIZ = st.hiz;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);

  sequence s_armed;
    commit && (st.arm_prev == 8'h00) && (st.arm == 8'h03);
  endsequence

  sequence s_new_batch(int c);
    commit && st.multi && (st.ch[c].ld == LD_IDLE) && (st.ch[c].ord_ctr != st.ch[c].ord_seen);
  endsequence

  AST_ARM_TAKES: assert property (s_armed |=> (st.ord == ORD_PEND)
      && (st.ord_time == $past(st.start)))
    else $error("armed order not taken");
  AST_ARM_ONLY: assert property ($rose(st.ord == ORD_PEND) |-> $past(accept))
    else $error("order pending without arm transition");
  AST_ORDER_EXEC: assert property (due_single && !accept |=> (st.ord == ORD_IDLE)
      ##2 (CH_HIZ == (st.multi ? 2'b00 : {st.fb[3], st.fb[1]})))
    else $error("due order not executed");
  AST_HIZ_WINS: assert property (!st.multi && $past(!st.multi) |-> (CH_OUT & CH_HIZ) == 2'b00)
    else $error("output driven while high impedance");
  AST_TICK_GAP: assert property (tick |=> !tick [*8])
    else $error("tick too frequent");
  AST_OVF_STICKY: assert property (st.ch[0].ovf && !f_flush[0] |=> st.ch[0].ovf)
    else $error("overflow cleared without flush");
  AST_FEEDBACK: assert property (s_new_batch(0) |=> (st.ch[0].ord_seen == $past(st.ch[0].ord_ctr)))
    else $error("order counter not echoed");
  AST_IN_COUNT: assert property (commit |=> st.in_ctr == $past(st.in_ctr) + 8'h01)
    else $error("input counter did not advance");
  AST_MANUAL: assert property (st.multi && st.ch[0].man_en |=> CH_OUT[0] == $past(st.ch[0].man_lvl))
    else $error("manual level not driven");
  AST_FLUSH: assert property (f_flush[0] |=> f_cnt[0] == '0)
    else $error("flush left events in buffer");
endmodule : tos_core
`default_nettype wire

//--- verif/bus_master.sv
`timescale 1ns/1ns
`default_nettype none
`include "tos_regs.svh"
// ****************************************************************
// cyclic master model
// ****************************************************************
module bus_master (
  input  wire logic        clk,
  output logic      [7:0]  addr,
  output logic      [31:0] wdata,
  output logic             wr,
  output logic             rd,
  input  wire logic [31:0] rdata
);
  initial begin
    addr  = 8'h00;
    wdata = 32'h0;
    wr    = 1'b0;
    rd    = 1'b0;
  end

  task automatic put(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : put

  task automatic get(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask : get

  task automatic commit();
    put(`TOS_A_CYCLE, 32'h0);
  endtask : commit

  // stage with arm idle, arm in the next cycle
  // caller picks a time several cycles ahead
  task automatic order(input logic [3:0] tgt, input logic [63:0] t);
    put(`TOS_A_ARM, {24'h0, `TOS_ARM_IDLE});
    put(`TOS_A_TGT, {28'h0, tgt});
    put(`TOS_A_START_LO, t[31:0]);
    put(`TOS_A_START_HI, t[63:32]);
    commit();
    put(`TOS_A_ARM, {24'h0, `TOS_ARM_GO});
    commit();
  endtask : order

  // stamps ascending caller bumps the counter
  task automatic batch(input logic [7:0] base, input logic [7:0] ctr, input logic [3:0] n,
                       input logic [9:0] lv, input logic [31:0] t0, input logic [31:0] step);
    for (int k = 0; k < 10; k++) begin
      put(base + 8'h04 + 8'(4 * k), t0 + step * 32'(k));
    end
    put(base, {2'h0, lv, n, ctr, 8'h00});
    commit();
    // loader needs time before entry words may be rewritten
    repeat (20) @(posedge clk);
  endtask : batch
endmodule : bus_master
`default_nettype wire

//--- verif/tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "tos_regs.svh"
module tb;
  localparam logic [63:0] BASE = 64'h0000_0001_0000_1000;
  logic        clk;
  logic        rst;
  logic [63:0] now;
  wire  [7:0]  addr;
  wire  [31:0] wdata;
  wire         wr;
  wire         rd;
  wire  [31:0] rdata;
  wire  [1:0]  ch_out;
  wire  [1:0]  ch_hiz;
  integer      err_total;
  integer      cmp_count;
  logic [31:0] v;
  logic [31:0] t0;
  logic [63:0] t;
  logic [63:0] at;
  logic [7:0]  a;

  bus_master mst (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  tos_core #(.DEPTH(16)) tos_core_inst (
    .CLK(clk), .SYS_RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .SYS_TIME(now), .CH_OUT(ch_out), .CH_HIZ(ch_hiz)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // system time in ns, one clock is 10 ns
  always @(posedge clk) begin
    now <= rst ? BASE : now + 64'hA;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic end_sim();
    $display("compares=%0d errors=%0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_sim

  task automatic wait_out(input int ch, input logic lv, output logic [63:0] when);
    int i;
    for (i = 0; i < 8000 && ch_out[ch] !== lv; i++) @(posedge clk);
    when = now;
    if (i == 8000) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, ch_out[ch], lv);
      end_sim();
    end
  endtask : wait_out

  initial begin
    err_total = 0;
    cmp_count = 0;
    rst       = 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    mst.get(8'h70, v);
    chk(v, 32'h0);
    mst.get(8'hFC, v);
    chk(v, 32'h0);
    // ****************************************************************
    // multi timestamp, channel 0 factor 2, three entries offered
    // ****************************************************************
    mst.put(`TOS_A_CTRL, 32'h5);
    t0 = now[31:0] + 32'd30000;
    mst.batch(8'h40, 8'h01, 4'h3, 10'h001, t0, 32'd30000);
    mst.get(8'h70, v);
    chk(v[8:0], 9'h002);
    chk(v[23:16], 8'h01);
    wait_out(0, 1'b1, at);
    chk(at[31:0] >= t0, 32'h1);
    chk(at[31:0] <= t0 + `TOS_TICK_NS + 100, 32'h1);
    mst.get(8'h70, v);
    chk(v[9:0], 10'h201);
    wait_out(0, 1'b0, at);
    chk(at[31:0] >= t0 + 32'd30000, 32'h1);
    // unchanged counter must not reload
    mst.put(8'h40, {2'h0, 10'h001, 4'h2, 8'h01, 8'h00});
    mst.commit();
    repeat (20) @(posedge clk);
    mst.get(8'h70, v);
    chk(v[9:0], 10'h000);
    // ****************************************************************
    // overflow, flush, manual
    // ****************************************************************
    mst.put(`TOS_A_CTRL, 32'hD);
    t0 = now[31:0] + 32'h4000_0000;
    mst.batch(8'h40, 8'h02, 4'hA, 10'h3FF, t0, 32'd1000);
    mst.get(8'h70, v);
    chk(v[8:0], 9'h00A);
    mst.batch(8'h40, 8'h03, 4'hA, 10'h3FF, t0 + 32'd20000, 32'd1000);
    mst.get(8'h70, v);
    chk(v[8:0], 9'h110);
    mst.put(8'h40, {2'h0, 10'h000, 4'h0, 8'h03, 8'h01});
    repeat (3) @(posedge clk);
    mst.get(8'h70, v);
    chk(v[8:0], 9'h000);
    mst.put(8'h40, {2'h0, 10'h000, 4'h0, 8'h03, 8'h0A});
    repeat (4) @(posedge clk);
    chk(ch_out[0], 1'b1);
    mst.put(8'h40, {2'h0, 10'h000, 4'h0, 8'h03, 8'h02});
    repeat (4) @(posedge clk);
    chk(ch_out[0], 1'b0);
    // ****************************************************************
    // time check on, no force: stale entry dropped, future one waits
    // ****************************************************************
    mst.put(`TOS_A_CTRL, 32'h7);
    t0 = now[31:0] - 32'd100000;
    mst.batch(8'h40, 8'h04, 4'h2, 10'h003, t0, 32'd130000);
    wait_out(0, 1'b1, at);
    chk(at[31:0] >= t0 + 32'd130000, 32'h1);
    chk(at[31:0] <= t0 + 32'd130000 + `TOS_TICK_NS + 100, 32'h1);
    // ****************************************************************
    // single order, replaced before it runs
    // ****************************************************************
    mst.put(`TOS_A_CTRL, 32'h0);
    mst.order(4'h4, now + 64'd2000000);
    t = now + 64'd40000;
    mst.order(4'h9, t);
    mst.get(`TOS_A_STATUS, v);
    chk(v[4], 1'b1);
    wait_out(0, 1'b1, at);
    chk(at >= t, 32'h1);
    chk(at <= t + `TOS_TICK_NS + 100, 32'h1);
    repeat (2) @(posedge clk);
    chk({ch_hiz, ch_out}, 4'h9);
    mst.get(`TOS_A_STATUS, v);
    chk(v[4:0], 5'h09);
    a = v[15:8];
    // arm byte still 3: no fresh order may be taken
    t = now + 64'd40000;
    mst.put(`TOS_A_TGT, 32'h0);
    mst.put(`TOS_A_START_LO, t[31:0]);
    mst.put(`TOS_A_START_HI, t[63:32]);
    mst.commit();
    mst.commit();
    mst.get(`TOS_A_STATUS, v);
    chk(v[15:0], {a + 8'h2, 8'h09});
    end_sim();
  end
endmodule : tb
`default_nettype wire
